// File: dv/pmo_ext_mem.sv
// external overlay memory answering reads on the program bus
`timescale 1ns/1ps
module pmo_ext_mem
(
   // bus from the map
   input  wire logic        clk_i,
   input  wire logic        sel_i,
   input  wire logic [13:0] addr_i,
   output logic      [23:0] rdata_o
);
   logic [23:0] junk_q = 24'h5A5A5A;
   // an idle bus toggles so stale data never matches
   always @(posedge clk_i) junk_q <= ~junk_q;
   // word echoes all 14 lines so the page bit shows in the data
   assign rdata_o = sel_i ? {10'h2A5, addr_i} : junk_q;
endmodule

// File: dv/pmo_map_checker.sv
// port assertions for the program memory overlay map
`timescale 1ns/1ps
module pmo_map_checker
(
   // watched ports
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [7:0]  prog_overlay_select_o,
   input wire logic        boot_enable_o,
   input wire logic        fetch_req_i,
   input wire logic        fetch_ext_o,
   input wire logic        data_req_i,
   input wire logic [13:0] data_addr_i,
   input wire logic [23:0] data_rdata_o,
   input wire logic        data_ext_o,
   input wire logic [13:0] ext_addr_o,
   input wire logic        ext_sel_o,
   input wire logic        ext_we_o,
   input wire logic [23:0] ext_rdata_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic up_d = data_req_i && data_addr_i[13];
   wire logic lo_d = data_req_i && !data_addr_i[13];
   sequence s_ovl_req; up_d && boot_enable_o && prog_overlay_select_o != 8'h00; endsequence
   a_upper_external: assert property (s_ovl_req |=> data_ext_o && ext_sel_o) else $error("upper half on chip");
   a_page_bit: assert property (s_ovl_req |=> ext_addr_o ==
      ($past(data_addr_i) & 14'h1FFF | {$past(prog_overlay_select_o) == 8'h02, 13'h0000})) else $error("bad ext address");
   a_lower_on_chip: assert property (lo_d && boot_enable_o |=> !data_ext_o) else $error("lower half left chip");
   a_zero_on_chip: assert property (fetch_req_i && !data_req_i && boot_enable_o &&
      prog_overlay_select_o == 8'h00 |=> !fetch_ext_o && !ext_sel_o) else $error("fetch left chip");
   a_strap_lower: assert property (lo_d && !boot_enable_o |=> data_ext_o && !ext_addr_o[13]) else $error("strap low");
   a_strap_upper: assert property (up_d && !boot_enable_o |=> !data_ext_o) else $error("strap upper");
   a_strap_clear: assert property (!boot_enable_o |=> prog_overlay_select_o == 8'h00) else $error("overlay kept");
   a_ext_read: assert property (data_ext_o |-> ext_sel_o && (ext_we_o || data_rdata_o == ext_rdata_i))
      else $error("external read lost");
endmodule
bind pmo_map pmo_map_checker u_chk
(
   .clk_i                 (clk_i),
   .rst_n_i               (rst_n_i),
   .prog_overlay_select_o (prog_overlay_select_o),
   .boot_enable_o         (boot_enable_o),
   .fetch_req_i           (fetch_req_i),
   .fetch_ext_o           (fetch_ext_o),
   .data_req_i            (data_req_i),
   .data_addr_i           (data_addr_i),
   .data_rdata_o          (data_rdata_o),
   .data_ext_o            (data_ext_o),
   .ext_addr_o            (ext_addr_o),
   .ext_sel_o             (ext_sel_o),
   .ext_we_o              (ext_we_o),
   .ext_rdata_i           (ext_rdata_i)
);

// File: dv/tb_top.sv
// self-checking bench for the program memory overlay map
`timescale 1ns/1ps
module tb_top;
   logic        clk_i = 0, rst_n_i = 0, mode_strap_i = 0, ovl_we_i = 0;
   logic        fetch_req_i = 0, data_req_i = 0, data_we_i = 0;
   logic        boot_enable_o, fetch_ext_o, data_ext_o, ext_sel_o, ext_we_o, ext_data_oe_o;
   logic [7:0]  ovl_wdata_i = 8'h00, prog_overlay_select_o;
   logic [13:0] fetch_addr_i = 14'h0000, data_addr_i = 14'h0000, ext_addr_o;
   logic [23:0] data_wdata_i = 24'h000000, fetch_data_o, data_rdata_o, ext_wdata_o, ext_rdata_i;
   int          n_errors = 0, checks = 0;
   pmo_map u_dut
   (
      .clk_i                 (clk_i),
      .rst_n_i               (rst_n_i),
      .mode_strap_i          (mode_strap_i),
      .ovl_we_i              (ovl_we_i),
      .ovl_wdata_i           (ovl_wdata_i),
      .prog_overlay_select_o (prog_overlay_select_o),
      .boot_enable_o         (boot_enable_o),
      .fetch_req_i           (fetch_req_i),
      .fetch_addr_i          (fetch_addr_i),
      .fetch_data_o          (fetch_data_o),
      .fetch_ext_o           (fetch_ext_o),
      .data_req_i            (data_req_i),
      .data_we_i             (data_we_i),
      .data_addr_i           (data_addr_i),
      .data_wdata_i          (data_wdata_i),
      .data_rdata_o          (data_rdata_o),
      .data_ext_o            (data_ext_o),
      .ext_addr_o            (ext_addr_o),
      .ext_sel_o             (ext_sel_o),
      .ext_we_o              (ext_we_o),
      .ext_wdata_o           (ext_wdata_o),
      .ext_data_oe_o         (ext_data_oe_o),
      .ext_rdata_i           (ext_rdata_i)
   );
   pmo_ext_mem u_mem (.clk_i(clk_i), .sel_i(ext_sel_o), .addr_i(ext_addr_o), .rdata_o(ext_rdata_i));
   always #10 clk_i = ~clk_i;
   // wide enough that a flag bit placed above a 24-bit word is compared too
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one data and one fetch slot, answer settled after return
   task automatic acc(input logic dq, we, input logic [13:0] a, input logic [23:0] wd, input logic fq,
                      input logic [13:0] fa);
      @(posedge clk_i);
      {data_req_i, data_we_i, data_addr_i, data_wdata_i, fetch_req_i, fetch_addr_i} <= {dq, we, a, wd, fq, fa};
      @(posedge clk_i);
      {data_req_i, data_we_i, fetch_req_i} <= 3'b000;
      #1;
   endtask
   task automatic set_ovl(input logic [7:0] v);
      @(posedge clk_i);
      {ovl_we_i, ovl_wdata_i} <= {1'b1, v};
      @(posedge clk_i);
      ovl_we_i <= 1'b0;
   endtask
   task automatic t_ram;
      acc(1, 1, 14'h0010, 24'hC0FFEE, 0, 0);
      acc(1, 1, 14'h3FFF, 24'hABCDEF, 0, 0);
      acc(1, 1, 14'h2010, 24'h123456, 0, 0);
      acc(1, 0, 14'h0010, 0, 1, 14'h3FFF);
      check("ram data", data_rdata_o, 24'hC0FFEE);
      check("ram fetch", {fetch_ext_o, fetch_data_o}, 24'hABCDEF);
      $display("ram test done");
   endtask
   task automatic t_ovl;
      for (int s = 1; s <= 2; s++)
      begin
         set_ovl(8'(s));
         acc(1, 0, 14'h2005, 0, 0, 0);
         check("ovl read", data_rdata_o, {10'h2A5, (s == 2), 13'h0005});
         acc(1, 1, 14'h3001, 24'h00BEEF, 0, 0);
         check("ovl wr bus", {ext_we_o, ext_data_oe_o, ext_addr_o}, {2'b11, (s == 2), 13'h1001});
         check("ovl wr data", ext_wdata_o, 24'h00BEEF);
         acc(1, 0, 14'h2003, 0, 1, 14'h2004);
         check("clash", {fetch_ext_o, data_ext_o, data_rdata_o[13:0]}, {2'b01, (s == 2), 13'h0003});
         acc(0, 0, 0, 0, 1, 14'h2007);
         check("ovl fetch", fetch_data_o, {10'h2A5, (s == 2), 13'h0007});
         acc(1, 0, 14'h0010, 0, 0, 0);
         check("lower kept", {data_ext_o, data_rdata_o}, 24'hC0FFEE);
      end
      set_ovl(8'h00);
      acc(0, 0, 0, 0, 1, 14'h2010);
      check("select zero", {fetch_ext_o, fetch_data_o}, 24'h123456);
      $display("overlay test done");
   endtask
   task automatic t_strap;
      set_ovl(8'h02);
      @(posedge clk_i);
      mode_strap_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1 check("strap", {boot_enable_o, prog_overlay_select_o}, 0);
      set_ovl(8'h01);
      acc(1, 0, 14'h2010, 0, 0, 0);
      check("strap upper", {data_ext_o, data_rdata_o}, 24'h123456);
      acc(1, 0, 14'h0005, 0, 0, 0);
      check("strap lower", data_rdata_o, {10'h2A5, 14'h0005});
      check("strap sel", prog_overlay_select_o, 0);
      @(posedge clk_i);
      mode_strap_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 check("strap off", boot_enable_o, 1);
      $display("strap test done");
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      check("reset", {boot_enable_o, prog_overlay_select_o}, 24'h000100);
      rst_n_i <= 1'b1;
      t_ram();
      t_ovl();
      t_strap();
      conclude();
   end
   initial
   begin
      #20000;
      n_errors++;
      conclude();
   end
endmodule

// File: logic/pmo_map.sv
// program memory address map with on-chip ram and external overlays
// ---------------------------------------------------------------
// Overview of operation
// - program space is 24 bits wide, holds code and data, backed by 16K words of on-chip ram.
// - the on-chip ram takes a fetch and a data access in the same cycle.
// - with overlay select zero and strap low all 16K words come from on-chip ram.
// - with strap low the lower half 0x0000-0x1FFF is always on-chip.
// - a nonzero overlay select sends 0x2000-0x3FFF to external memory.
// - external lines 12..0 carry the low 13 address bits, line 13 is low for overlay 1, high for overlay 2.
// - both 8K overlays are reached with only the 14 normal address lines.
// - strap high disables boot and overlays, hardware forces overlay select to zero.
// - the sequencer ignores overlay select and it is not saved on interrupts.
// ---------------------------------------------------------------
`timescale 1ns/1ps
module pmo_map
   import pmo_pkg::*;
#(
   parameter int ADDR_W = pmo_pkg::PMO_ADDR_W,
   parameter int DATA_W = pmo_pkg::PMO_DATA_W
)
(
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   // strap pin, asynchronous
   input  wire logic                         mode_strap_i,
   // overlay select write from the core
   input  wire logic                         ovl_we_i,
   input  wire logic [pmo_pkg::PMO_OVL_W-1:0] ovl_wdata_i,
   output logic      [pmo_pkg::PMO_OVL_W-1:0] prog_overlay_select_o,
   output logic                              boot_enable_o,
   // instruction fetch
   input  wire logic                         fetch_req_i,
   input  wire logic [ADDR_W-1:0]            fetch_addr_i,
   output logic      [DATA_W-1:0]            fetch_data_o,
   output logic                              fetch_ext_o,
   // data access
   input  wire logic                         data_req_i,
   input  wire logic                         data_we_i,
   input  wire logic [ADDR_W-1:0]            data_addr_i,
   input  wire logic [DATA_W-1:0]            data_wdata_i,
   output logic      [DATA_W-1:0]            data_rdata_o,
   output logic                              data_ext_o,
   // external program bus
   output logic      [ADDR_W-1:0]            ext_addr_o,
   output logic                              ext_sel_o,
   output logic                              ext_we_o,
   output logic      [DATA_W-1:0]            ext_wdata_o,
   output logic                              ext_data_oe_o,
   input  wire logic [DATA_W-1:0]            ext_rdata_i
);
   import pmo_pkg::*;

   // ---------------------------------------------------------------
   // strap synchroniser and overlay select register
   // ---------------------------------------------------------------
   logic                  strap_meta_q;
   logic                  strap_q;
   logic [PMO_OVL_W-1:0]  ovl_q;
   logic [PMO_OVL_W-1:0]  ovl_d;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         strap_meta_q <= 1'b0;
         strap_q      <= 1'b0;
      end
      else
      begin
         strap_meta_q <= mode_strap_i;
         strap_q      <= strap_meta_q;
      end
   end

   // strap high forces the select to zero so overlays stay off
   assign ovl_d = strap_q ? PMO_OVL_RESET : (ovl_we_i ? ovl_wdata_i : ovl_q);

   // plain register: no mode stack, the core must save it itself
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ovl_q <= PMO_OVL_RESET;
      end
      else
      begin
         ovl_q <= ovl_d;
      end
   end

   assign prog_overlay_select_o = ovl_q;
   assign boot_enable_o         = ~strap_q;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic is_ext(input logic [ADDR_W-1:0] a, input logic strap,
                                   input logic [PMO_OVL_W-1:0] ovl);
      logic upper;
      upper = a[PMO_SEG_BIT];
      if (strap)
         is_ext = ~upper;
      else
         is_ext = upper && (ovl != PMO_OVL_RESET);
   endfunction

   // overlay 2 raises the page bit, anything else nonzero uses overlay 1
   function automatic logic [ADDR_W-1:0] ext_map(input logic [ADDR_W-1:0] a, input logic strap,
                                               input logic [PMO_OVL_W-1:0] ovl);
      logic overlay_page_address_bit;
      overlay_page_address_bit = strap ? 1'b0 : (ovl == PMO_OVL_TWO);
      ext_map = {overlay_page_address_bit, a[PMO_SEG_W-1:0]};
   endfunction

   wire logic fetch_is_ext = is_ext(fetch_addr_i, strap_q, ovl_q);
   wire logic data_is_ext  = is_ext(data_addr_i, strap_q, ovl_q);
   wire logic data_go_ext  = data_req_i && data_is_ext;
   wire logic fetch_go_ext = fetch_req_i && fetch_is_ext && !data_go_ext;
   wire logic ram_we       = data_req_i && data_we_i && !data_is_ext;

   // ---------------------------------------------------------------
   // on-chip ram, both ports every cycle
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] ram_fetch_data;
   logic [DATA_W-1:0] ram_data_rdata;

   pmo_ram #(
      .DATA_W (DATA_W),
      .ADDR_W (ADDR_W),
      .WORDS  (PMO_RAM_WORDS)
   ) u_ram (
      .clk_i        (clk_i),
      .fetch_addr_i (fetch_addr_i),
      .fetch_data_o (ram_fetch_data),
      .data_addr_i  (data_addr_i),
      .data_we_i    (ram_we),
      .data_wdata_i (data_wdata_i),
      .data_rdata_o (ram_data_rdata)
   );

   // ---------------------------------------------------------------
   // external bus drive, registered
   // ---------------------------------------------------------------
   // the bus serves one access a cycle; data wins over fetch, a colliding
   // fetch reads as on-chip garbage and must be retried by the core
   logic [ADDR_W-1:0] ext_addr_q;
   logic              ext_we_q;
   logic [DATA_W-1:0] ext_wdata_q;
   logic              fetch_ext_q;
   logic              data_ext_q;
   wire  logic [ADDR_W-1:0] ext_addr_d = data_go_ext ? ext_map(data_addr_i, strap_q, ovl_q)
                                                      : ext_map(fetch_addr_i, strap_q, ovl_q);

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ext_addr_q  <= PMO_ADDR_RESET;
         ext_we_q    <= 1'b0;
         ext_wdata_q <= PMO_DATA_RESET;
         fetch_ext_q <= 1'b0;
         data_ext_q  <= 1'b0;
      end
      else
      begin
         ext_addr_q  <= ext_addr_d;
         ext_we_q    <= data_go_ext && data_we_i;
         ext_wdata_q <= data_wdata_i;
         fetch_ext_q <= fetch_go_ext;
         data_ext_q  <= data_go_ext;
      end
   end

   // ---------------------------------------------------------------
   // external cycle tracker
   // ---------------------------------------------------------------
   // the select pin follows this state, so a run of back-to-back external
   // accesses keeps the select high with no gap between words
   pmo_state_t ext_state_q;
   pmo_state_t ext_state_d;
   wire logic  ext_go = data_go_ext || fetch_go_ext;

   always_comb
   begin
      ext_state_d = ext_state_q;
      case (ext_state_q)
         PMO_ST_IDLE:
         begin
            if (ext_go)
            begin
               ext_state_d = PMO_ST_EXT;
            end
         end
         PMO_ST_EXT:
         begin
            if (!ext_go)
            begin
               ext_state_d = PMO_ST_IDLE;
            end
         end
         default:
         begin
            ext_state_d = PMO_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ext_state_q <= PMO_ST_IDLE;
      end
      else
      begin
         ext_state_q <= ext_state_d;
      end
   end

   assign ext_addr_o    = ext_addr_q;
   assign ext_sel_o     = (ext_state_q == PMO_ST_EXT);
   assign ext_we_o      = ext_we_q;
   assign ext_wdata_o   = ext_wdata_q;
   assign ext_data_oe_o = ext_we_q;
   assign fetch_ext_o   = fetch_ext_q;
   assign data_ext_o    = data_ext_q;

   // ---------------------------------------------------------------
   // read return, one cycle after the request
   // ---------------------------------------------------------------
   assign fetch_data_o = fetch_ext_q ? ext_rdata_i : ram_fetch_data;
   assign data_rdata_o = data_ext_q ? ext_rdata_i : ram_data_rdata;
endmodule

// File: logic/pmo_pkg.sv
// shared constants for the program memory overlay map
package pmo_pkg;
   localparam int          PMO_ADDR_W      = 14;
   localparam int          PMO_DATA_W      = 24;
   localparam int          PMO_SEG_W       = 13;
   localparam int          PMO_RAM_WORDS   = 16384;
   localparam int          PMO_OVL_W       = 8;
   localparam logic [7:0]  PMO_OVL_RESET   = 8'h00;
   localparam logic [7:0]  PMO_OVL_ONE     = 8'h01;
   localparam logic [7:0]  PMO_OVL_TWO     = 8'h02;
   localparam int          PMO_SEG_BIT     = 13;
   localparam logic [23:0] PMO_DATA_RESET  = 24'h000000;
   localparam logic [13:0] PMO_ADDR_RESET  = 14'h0000;
   typedef enum logic [1:0]
   {
      PMO_ST_IDLE = 2'b01,
      PMO_ST_EXT  = 2'b10
   } pmo_state_t;
endpackage

// File: logic/pmo_ram.sv
// dual-port on-chip program word store
`timescale 1ns/1ps
module pmo_ram
#(
   parameter int DATA_W = 24,
   parameter int ADDR_W = 14,
   parameter int WORDS  = 16384
)
(
   // clock
   input  wire logic              clk_i,
   // fetch port, read only
   input  wire logic [ADDR_W-1:0] fetch_addr_i,
   output logic      [DATA_W-1:0] fetch_data_o,
   // data port
   input  wire logic [ADDR_W-1:0] data_addr_i,
   input  wire logic              data_we_i,
   input  wire logic [DATA_W-1:0] data_wdata_i,
   output logic      [DATA_W-1:0] data_rdata_o
);
   logic [DATA_W-1:0] mem [WORDS];

   // no reset on the array: contents are loaded by software or boot
   always_ff @(posedge clk_i)
   begin
      if (data_we_i)
      begin
         mem[data_addr_i] <= data_wdata_i;
      end
      fetch_data_o <= mem[fetch_addr_i];
      data_rdata_o <= mem[data_addr_i];
   end
endmodule
